// *** core/lamp_defines.vh ***
/*
 Constants for the lamp enable and blink control block: register
 offsets, field positions, reset values, timer figures and the clock
 rate. Assumes it is included by bare name from the core design files.
*/
// Notes on behaviour
// - level register at 0x05, reset 0x00, bit7 zero
// - level bit 6 enables status lamp blinking
// - level bit 5 enables current ramp up/down
// - level bits 4:0 current code, 0.5mA steps
// - timing register at 0x07, reset 0x00
// - timing bits 7:6 blink off 512..4096ms
// - timing bits 5:4 blink on 128..1024ms
// - timing bits 3:2 ramp-up 128..1024ms
// - timing bits 1:0 ramp-down 128..1024ms
// - enable register at 0x09, reset 0x00
// - bits 7:6 status lamp off/on/pin-gated
// - bits 5:3 torch direct channel enables
// - torch codes 101/110/111 gated by pin
// - bits 2:0 strobe direct channel enables
// - strobe codes 101/110/111 gated by pin
`ifndef LAMP_DEFINES_VH
`define LAMP_DEFINES_VH

// register offsets
`define LAMP_ADDR_LEVEL      8'h05
`define LAMP_ADDR_TIMING     8'h07
`define LAMP_ADDR_ENABLE     8'h09
`define LAMP_ADDR_STATUS     8'h0F
`define LAMP_RESET_VALUE     8'h00

// level register fields
`define LAMP_BLINK_BIT       6
`define LAMP_RAMP_BIT        5
`define LAMP_CODE_MSB        4

// timing register fields
`define LAMP_OFF_MSB         7
`define LAMP_OFF_LSB         6
`define LAMP_ON_MSB          5
`define LAMP_ON_LSB          4
`define LAMP_RU_MSB          3
`define LAMP_RU_LSB          2
`define LAMP_RD_MSB          1
`define LAMP_RD_LSB          0

// enable register fields
`define LAMP_SEL_MSB         7
`define LAMP_SEL_LSB         6
`define LAMP_TORCH_MSB       5
`define LAMP_TORCH_LSB       3
`define LAMP_STROBE_MSB      2
`define LAMP_STROBE_LSB      0
`define LAMP_SEL_ON          2'h2
`define LAMP_SEL_PIN         2'h3

// timer figures in ms, shortest setting of each field
`define LAMP_OFF_BASE_MS     13'h0200
`define LAMP_ON_BASE_MS      13'h0080
`define LAMP_RAMP_BASE_MS    13'h0080
// ramp spans 32 current steps, so one step is the selected ramp time/32 ms
`define LAMP_RAMP_STEP_SHIFT 5

// clock and millisecond tick
`define LAMP_CLK_PERIOD_NS   4
`define LAMP_TICK_NS         1000000
`define LAMP_TICK_CYCLES     (`LAMP_TICK_NS / `LAMP_CLK_PERIOD_NS)

`endif

// *** core/lamp_ms_divider.v ***
/*
 Millisecond tick divider: a one-cycle enable pulse every DIV cycles.
 Assumes a single free-running clock and an asynchronous low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module lamp_ms_divider #(
   parameter integer DIV = 250000
) (
   // clock and reset
   input  wire        i_sys_clk,
   input  wire        i_arst_n,
   // control
   input  wire        i_restart,
   // tick out
   output reg         o_tick
);

   reg  [31:0] cnt_q;

   // restart keeps the first period whole after a state change
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q  <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (i_restart) begin
         cnt_q  <= 32'h00000000;
         o_tick <= 1'b0;
      end else if (cnt_q == DIV - 1) begin
         cnt_q  <= 32'h00000000;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h00000001;
         o_tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// *** core/lamp_channel_decode.v ***
/*
 Decoder for one three-bit high-current channel enable field.
 Assumes the gate pin is already synchronous to the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module lamp_channel_decode (
   // field and gate
   input  wire [2:0]  i_field,
   input  wire        i_gate,
   // channel enables, bit 0 is channel one
   output reg  [1:0]  o_enable
);

   // bit 2 selects pin gating; low bits name the channels
   // code 100 is unused and keeps both channels dark
   always @* begin
      case (i_field)
         3'h0:    o_enable = 2'h0;
         3'h1:    o_enable = 2'h1;
         3'h2:    o_enable = 2'h2;
         3'h3:    o_enable = 2'h3;
         3'h5:    o_enable = {1'b0, i_gate};
         3'h6:    o_enable = {i_gate, 1'b0};
         3'h7:    o_enable = {i_gate, i_gate};
         default: o_enable = 2'h0;
      endcase
   end

endmodule

`default_nettype wire

// *** core/lamp_enable_and_blink_control.v ***
/*
 Status lamp and high-current channel control: three host registers,
 the status lamp blink and ramp sequencer, and the torch and strobe
 channel enable decode.
 Offset 0x0F is a read-only view of the sequencer state.
 Assumes a register write/read port driven by the serial interface
 front end, synchronous to i_sys_clk, and a synchronous gate pin.
 The front end sends one-cycle strobes with address and data held
 for that cycle; a write and a read in the same cycle read the old
 value. The analog regulators sit outside and take the registered
 enables and current code below as plain levels.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lamp_defines.vh"

module lamp_enable_and_blink_control #(
   parameter integer TICK_CYCLES = `LAMP_TICK_CYCLES
) (
   // clock and reset
   input  wire        i_sys_clk,
   input  wire        i_arst_n,
   // register port
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [7:0]  i_reg_addr,
   input  wire [7:0]  i_reg_wdata,
   output reg  [7:0]  o_reg_rdata,
   // external gate
   input  wire        i_lamp_gate_pin,
   // status lamp regulator
   output reg         o_status_lamp_on,
   output reg  [4:0]  o_status_lamp_level_code,
   // high-current channels
   output reg         o_torch_channel_one,
   output reg         o_torch_channel_two,
   output reg         o_strobe_channel_one,
   output reg         o_strobe_channel_two
);

   // status lamp sequencer overview:
   //   off  - dark, waits for the lamp to become active
   //   up   - ramp, one level per step interval
   //   on   - lit at the programmed code, times the blink on period
   //   down - ramp back to dark, one level per step interval
   //   dark - blink off period, lamp held at zero current
   // levels run 0..32: 0 is dark and n drives code n-1, so a
   // ramp step is a 32nd of the ramp time whatever code is programmed; a small code
   // simply reaches its target earlier than a large one
   // a state change restarts the ms tick so no period is cut short
   // one-hot keeps each state decode to a single flop

   // sequencer states, one-hot
   localparam [4:0] ST_OFF  = 5'h01;
   localparam [4:0] ST_UP   = 5'h02;
   localparam [4:0] ST_ON   = 5'h04;
   localparam [4:0] ST_DOWN = 5'h08;
   localparam [4:0] ST_DARK = 5'h10;

   // period of a two-bit selection: base doubled per step
   // used for all four timers, so the doubling rule lives once
   // the widest result, 4096 ms, still fits in 13 bits
   function [12:0] period_ms;
      input [12:0] base;
      input [1:0]  sel;
      begin
         period_ms = base << sel;
      end
   endfunction

   // host registers and sequencer flops; all reset to zero except state_q, which resets to ST_OFF
   // level bit 7 is reserved and not stored, so it always reads 0
   reg  [6:0]  level_q;       // bit 7 is not stored
   reg  [7:0]  timing_q;
   reg  [7:0]  enable_q;
   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg  [5:0]  lvl_q;         // 0 is dark, n drives code n-1
   reg  [5:0]  lvl_d;
   reg  [12:0] ms_q;
   reg  [12:0] ms_d;

   // decoded fields and timer lengths
   wire        blink_on;
   wire        ramp_on;
   wire [4:0]  status_lamp_level_code;
   wire [1:0]  status_lamp_select;
   wire [1:0]  blink_off_time;
   wire [1:0]  blink_on_time;
   wire [1:0]  ramp_up_time;
   wire [1:0]  ramp_down_time;
   wire [5:0]  target;
   wire        lamp_active;
   wire        tick;
   wire        restart;
   wire [12:0] ms_next;
   wire [12:0] on_ms;
   wire [12:0] off_ms;
   wire [12:0] up_step_ms;
   wire [12:0] down_step_ms;
   wire [1:0]  torch_en;
   wire [1:0]  strobe_en;

   // field views
   // plain slices of the stored registers, no extra state
   // target is the level that drives the programmed code
   assign blink_on               = level_q[`LAMP_BLINK_BIT];
   assign ramp_on                = level_q[`LAMP_RAMP_BIT];
   assign status_lamp_level_code = level_q[`LAMP_CODE_MSB:0];
   assign blink_off_time         = timing_q[`LAMP_OFF_MSB:`LAMP_OFF_LSB];
   assign blink_on_time          = timing_q[`LAMP_ON_MSB:`LAMP_ON_LSB];
   assign ramp_up_time           = timing_q[`LAMP_RU_MSB:`LAMP_RU_LSB];
   assign ramp_down_time         = timing_q[`LAMP_RD_MSB:`LAMP_RD_LSB];
   assign status_lamp_select     = enable_q[`LAMP_SEL_MSB:`LAMP_SEL_LSB];
   assign target                 = {1'b0, status_lamp_level_code} + 6'h01;

   // 00 and 01 both keep the lamp off
   // pin-gated mode follows the pin level directly, so the pin
   // starts and stops the sequence just like a register write
   assign lamp_active = (status_lamp_select == `LAMP_SEL_ON) ||
                        ((status_lamp_select == `LAMP_SEL_PIN) && i_lamp_gate_pin);

   // timer lengths in ms
   // blink periods are whole ms counts; ramp time is split into
   // 32 equal steps, which is exact since every ramp base is a
   // multiple of 32 ms
   // counting in ms ticks keeps the counter at 13 bits for 4096 ms
   assign off_ms       = period_ms(`LAMP_OFF_BASE_MS, blink_off_time);
   assign on_ms        = period_ms(`LAMP_ON_BASE_MS, blink_on_time);
   assign up_step_ms   = period_ms(`LAMP_RAMP_BASE_MS, ramp_up_time)
                         >> `LAMP_RAMP_STEP_SHIFT;
   assign down_step_ms = period_ms(`LAMP_RAMP_BASE_MS, ramp_down_time)
                         >> `LAMP_RAMP_STEP_SHIFT;
   assign ms_next      = ms_q + 13'h0001;

   // a state change restarts the tick so each period starts whole
   // without this a period could lose up to one ms at its start,
   // which matters for the short ramp steps
   assign restart = (state_d != state_q);

   // shared ms tick; TICK_CYCLES is shortened in simulation only
   lamp_ms_divider #(
      .DIV (TICK_CYCLES)
   ) u_ms (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_restart (restart),
      .o_tick    (tick)
   );

   // torch and strobe fields share one decoder design
   // pin gating is combinational here and registered at the outputs
   lamp_channel_decode u_torch (
      .i_field  (enable_q[`LAMP_TORCH_MSB:`LAMP_TORCH_LSB]),
      .i_gate   (i_lamp_gate_pin),
      .o_enable (torch_en)
   );

   lamp_channel_decode u_strobe (
      .i_field  (enable_q[`LAMP_STROBE_MSB:`LAMP_STROBE_LSB]),
      .i_gate   (i_lamp_gate_pin),
      .o_enable (strobe_en)
   );

   // register map:
   //   0x05 level  : blink_on, ramp_on, status_lamp_level_code
   //   0x07 timing : blink_off_time, blink_on_time, ramp times
   //   0x09 enable : status_lamp_select, torch and strobe fields
   //   0x0F status : read only, writes are ignored
   // any other offset is ignored on write and reads zero
   // writes land at the strobe edge and act from the next cycle

   // register writes; reserved bit 7 of level is dropped
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         level_q  <= 7'h00;
         timing_q <= `LAMP_RESET_VALUE;
         enable_q <= `LAMP_RESET_VALUE;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `LAMP_ADDR_LEVEL:  level_q  <= i_reg_wdata[6:0];
            `LAMP_ADDR_TIMING: timing_q <= i_reg_wdata;
            `LAMP_ADDR_ENABLE: enable_q <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // read data registered; unmapped offsets read zero
   // data holds between reads so a slow front end can shift it out
   // status view: lamp on flag and the internal level 0..32
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `LAMP_ADDR_LEVEL:  o_reg_rdata <= {1'b0, level_q};
            `LAMP_ADDR_TIMING: o_reg_rdata <= timing_q;
            `LAMP_ADDR_ENABLE: o_reg_rdata <= enable_q;
            `LAMP_ADDR_STATUS: o_reg_rdata <= {1'b0, o_status_lamp_on, lvl_q};
            default:           o_reg_rdata <= 8'h00;
         endcase
      end
   end

   // status lamp sequencer
   // tick counts ms inside each state; ms_q is cleared on every
   // transition and every ramp step, so the next interval is whole
   always @* begin
      state_d = state_q;
      lvl_d   = lvl_q;
      ms_d    = tick ? ms_next : ms_q;
      case (state_q)
         // dark and idle until the lamp becomes active
         ST_OFF: begin
            lvl_d = 6'h00;
            ms_d  = 13'h0000;
            if (lamp_active) begin
               state_d = ramp_on ? ST_UP : ST_ON;
               lvl_d   = ramp_on ? 6'h00 : target;
            end
         end

         // climb one level per step until the target is reached
         ST_UP: begin
            if (!lamp_active) begin
               state_d = ST_DOWN;
               ms_d    = 13'h0000;
            end else if (!ramp_on || lvl_q >= target) begin
               state_d = ST_ON;
               lvl_d   = target;
               ms_d    = 13'h0000;
            end else if (tick && ms_next >= up_step_ms) begin
               lvl_d = lvl_q + 6'h01;
               ms_d  = 13'h0000;
            end
         end

         // lit; the blink on period runs only while blinking
         ST_ON: begin
            lvl_d = target; // follows code writes while lit
            if (!lamp_active) begin
               state_d = ramp_on ? ST_DOWN : ST_OFF;
               lvl_d   = ramp_on ? target : 6'h00;
               ms_d    = 13'h0000;
            end else if (!blink_on) begin
               ms_d = 13'h0000;
            end else if (tick && ms_next >= on_ms) begin
               state_d = ramp_on ? ST_DOWN : ST_DARK;
               lvl_d   = ramp_on ? target : 6'h00;
               ms_d    = 13'h0000;
            end
         end

         // fall one level per step; ramp off ends it at once
         ST_DOWN: begin
            if (lvl_q == 6'h00 || !ramp_on) begin
               state_d = (lamp_active && blink_on) ? ST_DARK : ST_OFF;
               lvl_d   = 6'h00;
               ms_d    = 13'h0000;
            end else if (tick && ms_next >= down_step_ms) begin
               lvl_d = lvl_q - 6'h01;
               ms_d  = 13'h0000;
            end
         end

         // blink off period, then light again
         ST_DARK: begin
            lvl_d = 6'h00;
            if (!lamp_active || !blink_on) begin
               state_d = ST_OFF;
               ms_d    = 13'h0000;
            end else if (tick && ms_next >= off_ms) begin
               state_d = ramp_on ? ST_UP : ST_ON;
               lvl_d   = ramp_on ? 6'h00 : target;
               ms_d    = 13'h0000;
            end
         end

         // an illegal code falls back to dark and idle
         default: begin
            state_d = ST_OFF;
            lvl_d   = 6'h00;
            ms_d    = 13'h0000;
         end
      endcase
   end

   // sequencer state
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= ST_OFF;
         lvl_q   <= 6'h00;
         ms_q    <= 13'h0000;
      end else begin
         state_q <= state_d;
         lvl_q   <= lvl_d;
         ms_q    <= ms_d;
      end
   end

   // registered status lamp outputs; level taken from the next
   // state so the regulator sees a change in the same cycle as lvl_q
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_status_lamp_on         <= 1'b0;
         o_status_lamp_level_code <= 5'h00;
      end else begin
         o_status_lamp_on         <= (lvl_d != 6'h00);
         o_status_lamp_level_code <= (lvl_d == 6'h00) ? 5'h00 : lvl_d[4:0] - 5'h01;
      end
   end

   // registered channel enables; the pin reaches them in one cycle
   // no interlock between torch and strobe, the analog side
   // decides which current wins when both are enabled
   always @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_torch_channel_one  <= 1'b0;
         o_torch_channel_two  <= 1'b0;
         o_strobe_channel_one <= 1'b0;
         o_strobe_channel_two <= 1'b0;
      end else begin
         o_torch_channel_one  <= torch_en[0];
         o_torch_channel_two  <= torch_en[1];
         o_strobe_channel_one <= strobe_en[0];
         o_strobe_channel_two <= strobe_en[1];
      end
   end

   // limitations: a code write while ramping up moves the end level at once,
   // one while ramping down shows at the next lit phase; a pin glitch of one cycle reaches the channel
   // enables, since the pin is taken as already clean; timing
   // figures hold only while TICK_CYCLES matches one ms of clock

endmodule

`default_nettype wire

// *** testbench/lamp_ctl_checker.sv ***
/*
 Checker for the lamp control block: register readback, channel decode,
 status lamp on/off and blink on time. Assumes it is bound to the top module.
*/
`timescale 1ns/100ps
`default_nettype none
module lamp_ctl_checker #(
   parameter integer TICK_CYCLES = 4
) (
   // clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_arst_n,
   // register port
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   // gate and outputs
   input wire logic       i_lamp_gate_pin,
   input wire logic       o_status_lamp_on,
   input wire logic [4:0] o_status_lamp_level_code,
   input wire logic       o_torch_channel_one,
   input wire logic       o_torch_channel_two,
   input wire logic       o_strobe_channel_one,
   input wire logic       o_strobe_channel_two
);
   logic [7:0]  lvl_q, tim_q, ena_q;
   logic [31:0] run_q;
   logic [1:0]  tdec_w, sdec_w;
   logic        act_w;
   logic [7:0]  mir_w;
   logic [31:0] on_w;
   function automatic logic [1:0] dec(input logic [2:0] f, input logic p);
      return (f[2] == 1'b0) ? f[1:0] : (f[1:0] & {2{p}});
   endfunction
   // mirrors of the host registers, bit 7 of level never stored
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lvl_q <= 8'h00;
         tim_q <= 8'h00;
         ena_q <= 8'h00;
         run_q <= 32'h0;
      end else begin
         if (i_reg_wr && i_reg_addr == 8'h05) lvl_q <= {1'b0, i_reg_wdata[6:0]};
         if (i_reg_wr && i_reg_addr == 8'h07) tim_q <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == 8'h09) ena_q <= i_reg_wdata;
         run_q <= o_status_lamp_on ? run_q + 32'h1 : 32'h0;   // lit run length
      end
   end
   assign act_w  = (ena_q[7:6] == 2'h2) || (ena_q[7:6] == 2'h3 && i_lamp_gate_pin);
   assign tdec_w = dec(ena_q[5:3], i_lamp_gate_pin);
   assign sdec_w = dec(ena_q[2:0], i_lamp_gate_pin);
   assign mir_w  = (i_reg_addr == 8'h05) ? lvl_q : (i_reg_addr == 8'h07) ? tim_q : ena_q;
   assign on_w   = (32'h80 << tim_q[5:4]) * TICK_CYCLES;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   chk_reg_read: assert property (i_reg_rd && (i_reg_addr == 8'h05 || i_reg_addr == 8'h07 ||
      i_reg_addr == 8'h09) |=> o_reg_rdata == $past(mir_w)) else $error("register readback wrong");
   chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
   chk_torch_dec: assert property ({o_torch_channel_two, o_torch_channel_one} == $past(tdec_w))
      else $error("torch decode wrong");
   chk_strobe_dec: assert property ({o_strobe_channel_two, o_strobe_channel_one} == $past(sdec_w))
      else $error("strobe decode wrong");
   chk_lamp_off: assert property ((!act_w && !lvl_q[5])[*3] |-> !o_status_lamp_on) else $error("lamp lit");
   chk_dark_code: assert property (!o_status_lamp_on |-> o_status_lamp_level_code == 5'h00)
      else $error("code while dark");
   chk_lamp_lit: assert property ((act_w && lvl_q[6:5] == 2'h0 && $stable(lvl_q))[*3] |->
      o_status_lamp_on && o_status_lamp_level_code == lvl_q[4:0]) else $error("lamp not lit");
   chk_blink_on: assert property (lvl_q[6:5] == 2'h2 && act_w && $fell(o_status_lamp_on) |->
      run_q >= on_w && run_q <= on_w + 32'h4) else $error("blink on period wrong");
endmodule
bind lamp_enable_and_blink_control lamp_ctl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_sys_clk(i_sys_clk),
   .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_lamp_gate_pin(i_lamp_gate_pin),
   .o_status_lamp_on(o_status_lamp_on), .o_status_lamp_level_code(o_status_lamp_level_code),
   .o_torch_channel_one(o_torch_channel_one), .o_torch_channel_two(o_torch_channel_two),
   .o_strobe_channel_one(o_strobe_channel_one), .o_strobe_channel_two(o_strobe_channel_two));
`default_nettype wire

// *** testbench/lamp_host_model.sv ***
/*
 Host model: register port master and lamp gate pin driver.
 Assumes one clock; everything changes just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module lamp_host_model (
   // clock
   input  wire logic       i_sys_clk,
   // register port
   output var  logic       o_reg_wr,
   output var  logic       o_reg_rd,
   output var  logic [7:0] o_reg_addr,
   output var  logic [7:0] o_reg_wdata,
   input  wire logic [7:0] i_reg_rdata,
   // gate pin
   output var  logic       o_gate_pin
);
   initial {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata, o_gate_pin} = 19'h0;
   // one-cycle strobe; released bus shows inverted values, never stale ones
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b1;
      o_reg_addr  <= a;
      o_reg_wdata <= d;
      @(posedge i_sys_clk);
      o_reg_wr    <= 1'b0;
      o_reg_addr  <= ~a;
      o_reg_wdata <= ~d;
   endtask
   // data is taken at the falling edge half a cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg_rd   <= 1'b1;
      o_reg_addr <= a;
      @(posedge i_sys_clk);
      o_reg_rd   <= 1'b0;
      o_reg_addr <= ~a;
      @(negedge i_sys_clk);
      d = i_reg_rdata;
   endtask
   task automatic set_pin(input logic v);
      @(posedge i_sys_clk);
      o_gate_pin <= v;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
 Testbench for the lamp control block: decode table, reset values,
 blink and ramp timing, reset in mid-run. Assumes a 1 ms tick of 4 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic       i_sys_clk = 1'b0;
   logic       i_arst_n  = 1'b0;
   logic       reg_wr, reg_rd, gate_pin, lamp_on, t1, t2, s1, s2, mono;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [4:0] code, prev;
   int         miscompares = 0;
   int         check_count = 0;
   int         n, k, j, len;
   // rows: field, channels with pin low, channels with pin high
   logic [6:0] rows [8] = '{7'h00, 7'h15, 7'h2A, 7'h3F, 7'h40, 7'h51, 7'h62, 7'h73};
   always #2 i_sys_clk = ~i_sys_clk;
   lamp_enable_and_blink_control #(.TICK_CYCLES(4)) dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .i_lamp_gate_pin(gate_pin), .o_status_lamp_on(lamp_on),
      .o_status_lamp_level_code(code), .o_torch_channel_one(t1), .o_torch_channel_two(t2),
      .o_strobe_channel_one(s1), .o_strobe_channel_two(s2));
   lamp_host_model host (.i_sys_clk(i_sys_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
      .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata), .o_gate_pin(gate_pin));
   task automatic note(input bit bad, input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (bad) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      note(g !== e, g, e);
   endtask
   task automatic cmp_out(input logic [4:0] g, input logic [4:0] e);
      note(g !== e, g, e);
   endtask
   task automatic cmp_len(input int g, input int lo, input int hi);
      note(g < lo || g > hi, g, lo);
   endtask
   // cycles until the lamp reaches level v, code must move one way only
   task automatic wait_lamp(input logic v, input bit up);
      len  = 0;
      mono = 1'b1;
      prev = code;
      while (lamp_on !== v && len < 10000) begin
         @(negedge i_sys_clk);
         len++;
         if (up ? code < prev : code > prev) mono = 1'b0;
         prev = code;
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge i_sys_clk);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      for (n = 0; n < 3; n++) begin
         host.rd_reg(8'h05 + 8'(2 * n), rd);
         cmp_reg(rd, 8'h00);
      end
      host.wr_reg(8'h05, 8'hFF);
      host.rd_reg(8'h05, rd);
      cmp_reg(rd, 8'h7F);
      host.wr_reg(8'h07, 8'hA5);
      host.wr_reg(8'h06, 8'h33);
      host.rd_reg(8'h07, rd);
      cmp_reg(rd, 8'hA5);
      host.wr_reg(8'h05, 8'h1F);
      // every field code against both pin levels, lamp follows the pin
      for (n = 0; n < 8; n++) for (k = 0; k < 2; k++) begin
         j = (n + 3) % 8;
         host.set_pin(k[0]);
         host.wr_reg(8'h09, {2'h3, rows[n][6:4], rows[j][6:4]});
         host.rd_reg(8'h09, rd);
         cmp_reg(rd, {2'h3, rows[n][6:4], rows[j][6:4]});
         cmp_out({lamp_on, t2, t1, s2, s1}, {k[0], k[0] ? {rows[n][1:0], rows[j][1:0]} :
            {rows[n][3:2], rows[j][3:2]}});
         cmp_out(code, k[0] ? 5'h1F : 5'h00);
      end
      for (n = 0; n < 3; n++) begin
         host.wr_reg(8'h09, {n[1:0], 6'h00});
         host.rd_reg(8'h09, rd);
         cmp_reg(rd, {n[1:0], 6'h00});
         cmp_out({4'h0, lamp_on}, {4'h0, n == 2});
      end
      // blink, shortest on and off periods
      host.wr_reg(8'h09, 8'h00);
      host.wr_reg(8'h07, 8'h00);
      host.wr_reg(8'h05, 8'h4A);
      host.wr_reg(8'h09, 8'h80);
      wait_lamp(1'b1, 1'b1);
      cmp_out(code, 5'h0A);
      wait_lamp(1'b0, 1'b1);
      cmp_len(len, 511, 516);
      wait_lamp(1'b1, 1'b1);
      cmp_len(len, 2047, 2052);
      // ramp up in 256 ms, down in 128 ms
      host.wr_reg(8'h09, 8'h00);
      host.wr_reg(8'h05, 8'h3F);
      host.wr_reg(8'h07, 8'h04);
      repeat (600) @(posedge i_sys_clk);
      host.wr_reg(8'h09, 8'h80);
      wait_lamp(1'b1, 1'b1);
      // count from the first lit cycle until the top code shows
      len  = 0;
      mono = 1'b1;
      prev = code;
      while (code !== 5'h1F && len < 4000) begin
         @(negedge i_sys_clk);
         len++;
         if (code < prev) mono = 1'b0;
         prev = code;
      end
      cmp_len(len, 992, 1040);
      cmp_out({4'h0, mono}, 5'h01);
      host.wr_reg(8'h09, 8'h00);
      wait_lamp(1'b0, 1'b0);
      cmp_len(len, 480, 530);
      cmp_out({4'h0, mono}, 5'h01);
      // reset in mid-run clears outputs and registers
      host.wr_reg(8'h09, 8'h9B);
      host.rd_reg(8'h09, rd);
      @(posedge i_sys_clk);
      i_arst_n <= 1'b0;
      @(negedge i_sys_clk);
      cmp_out({lamp_on, t2, t1, s2, s1}, 5'h00);
      @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      host.rd_reg(8'h09, rd);
      cmp_reg(rd, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
